// ---- rtl/sdc_divider_sync.sv ----
`timescale 1ns/1ns
// Operation
// - divide sample clock by one to eight
// - external alignment input realigns divider phase
// - control bits pick every-pulse or first-pulse realignment
// - accepted pulse returns divider to initial state
// - regenerate falling edge for half-period high time
// - regeneration off below minimum clock rate
// - sample on divided rising edge, never retimed
module sdc_divider_sync
  import sdc_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic sample_clk_in,
  input wire logic sync_in,
  input wire logic [sdc_pkg::DIV_W-1:0] div_ratio_m1,
  input wire logic regen_enable,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [sdc_pkg::REG_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic div_clk_raw,
  output logic sample_strobe,
  output logic div_clk_out,
  output logic regen_locked
);
  import sdc_pkg::*;

  logic clk_q;
  logic sync_q;
  logic in_rise;
  logic sync_rise;
  logic [7:0] ctrl;
  logic armed;
  logic write_hit;
  logic read_hit;
  sdc_mode_e mode;
  logic sync_accept;
  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic [DIV_W-1:0] half;
  logic wrap;
  logic div_rise;

  // ----------------------------------------------------------------
  // input edge detection
  // ----------------------------------------------------------------
  // inputs are already synchronous, so one stage is enough for edges
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      clk_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      clk_q <= sample_clk_in;
      sync_q <= sync_in;
    end
  end

  assign in_rise = sample_clk_in && !clk_q;
  // a long alignment level counts once, on its leading edge
  assign sync_rise = sync_in && !sync_q;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  assign write_hit = reg_wr && (reg_addr == SYNC_CTRL_ADDR);
  assign read_hit = reg_rd && (reg_addr == SYNC_CTRL_ADDR);

  // only the two mode bits are stored; bit 2 reads the armed flag, the rest read as zero
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      ctrl <= SYNC_CTRL_RESET;
    end
    else if (write_hit)
    begin
      ctrl <= reg_wdata & SYNC_CTRL_WMASK;
    end
  end

  // readback carries the armed flag so software sees a consumed one-shot
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      reg_rdata <= 8'h00;
    end
    else if (read_hit)
    begin
      reg_rdata <= ctrl | (8'(armed) << SYNC_ARMED_BIT);
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end

  assign mode = sdc_decode_mode(ctrl);

  // ----------------------------------------------------------------
  // alignment acceptance
  // ----------------------------------------------------------------
  assign sync_accept = sync_rise &&
    ((mode == SDC_SYNC_EVERY) || ((mode == SDC_SYNC_ONCE) && armed));

  // a write re-arms; it wins over a pulse consumed in the same cycle
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      armed <= 1'b0;
    end
    else if (write_hit)
    begin
      armed <= 1'b1;
    end
    else if (sync_accept && (mode == SDC_SYNC_ONCE))
    begin
      armed <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // integer divider
  // ----------------------------------------------------------------
  // a ratio change applies to the interval in progress, a count above it wraps on the next input edge
  assign wrap = (count >= div_ratio_m1);
  assign next_count = wrap ? '0 : count + 1'b1;
  assign half = div_ratio_m1 >> 1;
  assign div_rise = in_rise && !sync_accept && wrap;

  // initial state parks the count on its last step so the first input
  // edge after alignment is always the divided edge
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      count <= '0;
    end
    else
    begin
      case (1'b1)
        sync_accept:
        begin
          count <= div_ratio_m1;
        end
        in_rise:
        begin
          count <= next_count;
        end
        default:
        begin
          count <= count;
        end
      endcase
    end
  end

  // raw divided clock, high for the first half of the count
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      div_clk_raw <= 1'b0;
    end
    else if (sync_accept)
    begin
      div_clk_raw <= 1'b0;
    end
    else if (div_ratio_m1 == '0)
    begin
      div_clk_raw <= sample_clk_in;
    end
    else if (in_rise)
    begin
      div_clk_raw <= (next_count <= half);
    end
  end

  // one pulse per divided rising edge, the point where a sample is taken
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      sample_strobe <= 1'b0;
    end
    else
    begin
      sample_strobe <= div_rise;
    end
  end

  // ----------------------------------------------------------------
  // duty-cycle regenerator
  // ----------------------------------------------------------------
  sdc_duty_regen #(
    .PERIOD_W(8)
  ) u_duty_cycle_regenerator (
    .clock(clock),
    .resetn(resetn),
    .rise(div_rise),
    .raw_clk(div_clk_raw),
    .enable(regen_enable),
    .clk_out(div_clk_out),
    .locked(regen_locked)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_align;
    sync_accept;
  endsequence

  sequence s_first_edge;
    in_rise && !sync_accept;
  endsequence

  a_ratio_wrap: assert property ((in_rise && !sync_accept && wrap) |=> (count == '0))
    else $error("divider did not wrap at programmed ratio");
  a_count_step: assert property ((in_rise && !sync_accept && !wrap) |=>
    (count == $past(count) + 1'b1))
    else $error("divider did not advance on input edge");
  a_sync_align: assert property (s_align |=> (count == $past(div_ratio_m1) && !div_clk_raw))
    else $error("accepted alignment did not reset divider");
  a_sync_off_ignored: assert property ((mode == SDC_SYNC_OFF && sync_rise) |-> !sync_accept)
    else $error("alignment accepted while disabled");
  a_every_accepts: assert property ((mode == SDC_SYNC_EVERY && sync_rise) |-> sync_accept)
    else $error("alignment refused in every-pulse mode");
  a_once_disarm: assert property ((s_align and (mode == SDC_SYNC_ONCE && !write_hit)) |=>
    !armed ##0 (!sync_rise || mode != SDC_SYNC_ONCE || write_hit || armed || !sync_accept))
    else $error("one-shot alignment not consumed");
  a_write_arms: assert property (write_hit |=> armed)
    else $error("register write did not re-arm alignment");
  a_first_edge_fixed: assert property ((s_align ##1 s_first_edge) |=> sample_strobe)
    else $error("first divided edge not at fixed latency");
  a_strobe_on_rise: assert property (sample_strobe |-> $past(in_rise))
    else $error("sample strobe without input rising edge");
endmodule

// ---- rtl/sdc_pkg.sv ----
package sdc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int REGEN_MIN_MHZ = 20;
  // longest input period, in system cycles, that the regenerator still handles
  localparam int REGEN_MAX_PERIOD_CYC = CLK_MHZ / REGEN_MIN_MHZ;
  localparam int RELOCK_MIN_NS = 1500;
  localparam int RELOCK_MAX_NS = 5000;
  localparam int RELOCK_MIN_CYC = (RELOCK_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int RELOCK_MAX_CYC = (RELOCK_MAX_NS * CLK_MHZ) / 1000;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  localparam int DIV_MAX = 8;
  localparam int DIV_W = $clog2(DIV_MAX);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int REG_ADDR_W = 13;
  localparam logic [REG_ADDR_W-1:0] SYNC_CTRL_ADDR = 13'h109;
  localparam int SYNC_EN_BIT = 0;
  localparam int SYNC_ONCE_BIT = 1;
  localparam int SYNC_ARMED_BIT = 2;
  localparam logic [7:0] SYNC_CTRL_RESET = 8'h00;
  localparam logic [7:0] SYNC_CTRL_WMASK = 8'h03;

  typedef enum logic [1:0] {SDC_SYNC_OFF, SDC_SYNC_EVERY, SDC_SYNC_ONCE} sdc_mode_e;

  // realignment mode from the control byte
  function automatic sdc_mode_e sdc_decode_mode(input logic [7:0] ctrl);
    sdc_mode_e m;
    m = SDC_SYNC_OFF;
    if (ctrl[SYNC_EN_BIT])
    begin
      m = ctrl[SYNC_ONCE_BIT] ? SDC_SYNC_ONCE : SDC_SYNC_EVERY;
    end
    return m;
  endfunction

endpackage

// ---- rtl/sdc_duty_regen.sv ----
`timescale 1ns/1ns
module sdc_duty_regen
  import sdc_pkg::*;
#(
  parameter int PERIOD_W = 8
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic rise,
  input wire logic raw_clk,
  input wire logic enable,
  output logic clk_out,
  output logic locked
);
  localparam logic [PERIOD_W-1:0] PMAX = {PERIOD_W{1'b1}};
  localparam logic [PERIOD_W-1:0] PERIOD_LIMIT = PERIOD_W'(REGEN_MAX_PERIOD_CYC);
  localparam logic [PERIOD_W-1:0] PERIOD_FLOOR = PERIOD_W'(2);
  localparam logic [15:0] LOCK_CYC = 16'(RELOCK_MIN_CYC);

  logic [PERIOD_W-1:0] pcnt;
  logic [PERIOD_W-1:0] period;
  logic [PERIOD_W-1:0] hcnt;
  logic [PERIOD_W-1:0] new_period;
  logic [15:0] stable_cnt;
  logic regen_q;
  logic use_regen;

  assign new_period = (pcnt == PMAX) ? PMAX : pcnt + 1'b1;

  // ----------------------------------------------------------------
  // period measurement, saturating so a clock slower than PMAX cycles reads as PMAX
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pcnt <= '0;
      period <= PMAX;
    end
    else if (rise)
    begin
      pcnt <= '0;
      period <= new_period;
    end
    else if (pcnt != PMAX)
    begin
      pcnt <= pcnt + 1'b1;
    end
  end

  // regenerated high phase: rises with the divided edge, falls at half period
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      hcnt <= '0;
      regen_q <= 1'b0;
    end
    else if (rise)
    begin
      hcnt <= '0;
      regen_q <= 1'b1;
    end
    else
    begin
      if (hcnt != PMAX)
      begin
        hcnt <= hcnt + 1'b1;
      end
      if ((hcnt + 1'b1) >= (period >> 1))
      begin
        regen_q <= 1'b0;
      end
    end
  end

  // loop lock: a changed period restarts the settle time
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      stable_cnt <= '0;
    end
    else if (rise && (new_period != period))
    begin
      stable_cnt <= '0;
    end
    else if (stable_cnt < LOCK_CYC)
    begin
      stable_cnt <= stable_cnt + 1'b1;
    end
  end

  assign locked = (stable_cnt >= LOCK_CYC);
  // too slow for the loop: the raw divided clock passes untouched
  assign use_regen = enable && locked && (period <= PERIOD_LIMIT) && (period >= PERIOD_FLOOR);
  // the rising edge is common to both sources, only the falling edge moves
  assign clk_out = use_regen ? regen_q : raw_clk;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_regen_rise_edge: assert property (rise |=> regen_q)
    else $error("regenerated clock did not rise with divided edge");
  a_regen_half_high: assert property ((rise && new_period == PERIOD_W'(4)) |=>
    regen_q ##1 (rise || regen_q) ##1 (rise || !regen_q))
    else $error("regenerated high time not half of period four");
  a_slow_bypass: assert property ((period > PERIOD_LIMIT) |-> (clk_out == raw_clk))
    else $error("regenerator active below minimum rate");
  a_relock_wait: assert property ((rise && new_period != period) |=> !locked [*8])
    else $error("lock reported too soon after period change");
endmodule

// ---- dv/sdc_clk_src.sv ----
`timescale 1ns/1ns
module sdc_clk_src
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [3:0] hi,
  input wire logic [3:0] lo,
  input wire logic sync_req,
  output logic sample_clk_in,
  output logic sync_in
);
  logic [3:0] ph;
  logic pend;
  // ------------------------------------------------------------
  // sample clock and alignment pulse source
  // ------------------------------------------------------------
  // free running; hi and lo may change mid-run to step the rate
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      ph <= 4'h0;
      sample_clk_in <= 1'b0;
    end
    else if (ph + 4'h1 >= (sample_clk_in ? hi : lo))
    begin
      ph <= 4'h0;
      sample_clk_in <= ~sample_clk_in;
    end
    else
      ph <= ph + 4'h1;
  end
  // one-cycle pulse early in the low phase, so with lo of 2 or more it never meets a rising edge
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pend <= 1'b0;
      sync_in <= 1'b0;
    end
    else
    begin
      sync_in <= pend && ph == 4'h0 && !sample_clk_in;
      if (sync_req)
        pend <= 1'b1;
      else if (ph == 4'h0 && !sample_clk_in)
        pend <= 1'b0;
    end
  end
endmodule

// ---- dv/sdc_divider_sync_test.sv ----
`timescale 1ns/1ns
`define CHK(a, e) \
  begin \
    checked++; \
    if ((a) !== (e)) \
    begin \
      failures++; \
      $display("CHECK FAILED %0t got %0h exp %0h", $time, a, e); \
    end \
  end
module sdc_divider_sync_test;
  import sdc_pkg::*;
  logic clock, resetn, sample_clk_in, sync_in, regen_enable, reg_wr, reg_rd, sync_req;
  logic [DIV_W-1:0] div_ratio_m1;
  logic [REG_ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd;
  logic [3:0] hi, lo;
  logic div_clk_raw, sample_strobe, div_clk_out, regen_locked;
  int failures, checked, n;

  sdc_divider_sync u_sdc_divider_sync (.clock(clock), .resetn(resetn),
    .sample_clk_in(sample_clk_in), .sync_in(sync_in), .div_ratio_m1(div_ratio_m1),
    .regen_enable(regen_enable), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .div_clk_raw(div_clk_raw),
    .sample_strobe(sample_strobe), .div_clk_out(div_clk_out), .regen_locked(regen_locked));
  sdc_clk_src u_sdc_clk_src (.clock(clock), .resetn(resetn), .hi(hi), .lo(lo),
    .sync_req(sync_req), .sample_clk_in(sample_clk_in), .sync_in(sync_in));

  // ------------------------------------------------------------
  // clock and helpers
  // ------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic conclude;
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic stuck;
    failures++;
    $display("CHECK FAILED %0t wait ran out", $time);
    conclude();
  endtask

  task automatic reg_write(input logic [REG_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // read data is registered, so it is taken one cycle after the strobe
  task automatic reg_read(input logic [REG_ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask

  task automatic to_strobe(output int c);
    c = 0;
    do
    begin
      @(negedge clock);
      c++;
      if (c > 400)
        stuck();
    end
    while (sample_strobe !== 1'b1);
  endtask

  // raw selects the divided clock, else the input clock
  task automatic to_rise(input bit raw);
    logic p;
    p = raw ? div_clk_raw : sample_clk_in;
    for (int i = 0; i < 400; i++)
    begin
      @(negedge clock);
      if (!p && (raw ? div_clk_raw : sample_clk_in))
        return;
      p = raw ? div_clk_raw : sample_clk_in;
    end
    stuck();
  endtask

  task automatic wait_lock(input logic v, output int c);
    for (c = 0; regen_locked !== v; c++)
    begin
      @(negedge clock);
      if (c > 1000)
        stuck();
    end
  endtask

  task automatic hi_time(output int c);
    for (c = 0; div_clk_out === 1'b1 && c < 50; c++)
      @(negedge clock);
  endtask

  // sync well away from a divided edge: a realigned divider strobes on the next input edge
  task automatic realign(input logic e);
    int c;
    to_strobe(c);
    repeat (8) @(negedge clock);
    @(posedge clock);
    sync_req <= 1'b1;
    @(posedge clock);
    sync_req <= 1'b0;
    for (int i = 0; i < 40 && sync_in !== 1'b1; i++)
      @(negedge clock);
    // a pulse that never shows is a dead source, not a refused alignment
    if (sync_in !== 1'b1)
      stuck();
    to_rise(1'b0);
    @(negedge clock);
    `CHK(sample_strobe, e)
    `CHK(div_clk_raw, e)
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    sync_req = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = 8'h00;
    div_ratio_m1 = '0;
    regen_enable = 1'b0;
    hi = 4'h2;
    lo = 4'h2;
    failures = 0;
    checked = 0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    reg_read(SYNC_CTRL_ADDR, rd);
    `CHK(rd, SYNC_CTRL_RESET)
    reg_write(SYNC_CTRL_ADDR, 8'hFF);
    reg_read(SYNC_CTRL_ADDR, rd);
    `CHK(rd, 8'h07)
    reg_read(SYNC_CTRL_ADDR + 13'h1, rd);
    `CHK(rd, 8'h00)
    // every ratio; the interval in progress mixes old and new ratio, so skip two intervals
    for (int r = 1; r <= DIV_MAX; r++)
    begin
      @(posedge clock);
      div_ratio_m1 <= DIV_W'(r - 1);
      to_strobe(n);
      to_strobe(n);
      to_strobe(n);
      `CHK(n, 4 * r)
    end
    realign(1'b1);
    reg_read(SYNC_CTRL_ADDR, rd);
    `CHK(rd, 8'h03)
    realign(1'b0);
    reg_write(SYNC_CTRL_ADDR, 8'h01);
    realign(1'b1);
    realign(1'b1);
    reg_write(SYNC_CTRL_ADDR, 8'h00);
    realign(1'b0);
    // slow narrow input clock: stabilizer stays out of the path
    @(posedge clock);
    div_ratio_m1 <= '0;
    hi <= 4'h1;
    lo <= 4'h9;
    regen_enable <= 1'b1;
    to_rise(1'b1);
    `CHK(div_clk_out, 1'b1)
    hi_time(n);
    `CHK(n, 1)
    // rate step into the stabilizer's range, then relock
    wait_lock(1'b1, n);
    @(posedge clock);
    lo <= 4'h4;
    wait_lock(1'b0, n);
    wait_lock(1'b1, n);
    `CHK(n >= RELOCK_MIN_CYC - 2 && n <= RELOCK_MAX_CYC, 1'b1)
    to_rise(1'b1);
    `CHK(div_clk_out, 1'b1)
    hi_time(n);
    `CHK(n, 2)
    conclude();
  end
endmodule
